//--- common/dmad_regs.svh
// Opcode encodings, field positions and minimum clock counts for the decoder
// Behaviour
// - Byte 8E with addressing byte copies into segment register; 2 or 9 clocks.
// - Byte 8C with addressing byte copies segment register out; 2 or 11 clocks.
// - Single byte D7 replaces low accumulator byte from table; 11 clocks minimum.
// - Byte 8D loads effective address into register, no memory access; 6 clocks.
// - Byte C5 loads far pointer with data segment; mode 11 illegal; 18 clocks.
// - Byte C4 loads far pointer with extra segment; memory forms only; 18 clocks.
// - Single byte 9F copies low flag byte into high accumulator byte; 2 clocks.
// - Single byte 9E writes high accumulator byte into low flags; 3 clocks.
// - Segment override prefixes redirect next memory operand; each costs 2 clocks (the decoder adds none for them).
// - Register/memory addition takes 3 clocks with registers, 10 with memory.
// - Add with carry 000100dw takes 3/10; 0001010w immediate takes 3/4.
// - Counts are minimums assuming prefetched operands and no waits or holds.
// - Memory instructions may take two extra clocks for handshake.
`ifndef DMAD_REGS_SVH
`define DMAD_REGS_SVH
`define OPC_SEG_LOAD     8'h8E
`define OPC_SEG_STORE    8'h8C
`define OPC_TABLE_LOOKUP 8'hD7
`define OPC_EA_LOAD      8'h8D
`define OPC_FAR_DS       8'hC5
`define OPC_FAR_ES       8'hC4
`define OPC_FLAGS_TO_AH  8'h9F
`define OPC_AH_TO_FLAGS  8'h9E
`define OPC_PFX_ES       8'h26
`define OPC_PFX_CS       8'h2E
`define OPC_PFX_SS       8'h36
`define OPC_PFX_DS       8'h3E
`define OPC_ADD_RM_MASK  8'hFC
`define OPC_ADD_RM       8'h00
`define OPC_ADC_RM       8'h10
`define OPC_IMM_MASK     8'hFE
`define OPC_ADD_IMM      8'h04
`define OPC_ADC_IMM      8'h14
`define MODRM_MOD_HI     7
`define MODRM_MOD_LO     6
`define MOD_REGISTER     2'h3
`define OPC_W_BIT        0
`define CLK_SEG_LOAD_R   6'h02
`define CLK_SEG_LOAD_M   6'h09
`define CLK_SEG_STORE_R  6'h02
`define CLK_SEG_STORE_M  6'h0B
`define CLK_TABLE_LOOKUP 6'h0B
`define CLK_EA_LOAD      6'h06
`define CLK_FAR_LOAD     6'h12
`define CLK_FLAGS_TO_AH  6'h02
`define CLK_AH_TO_FLAGS  6'h03
`define CLK_PREFIX       6'h02
`define CLK_ADD_R        6'h03
`define CLK_ADD_M        6'h0A
`define CLK_ADD_IMM8     6'h03
`define CLK_ADD_IMM16    6'h04
`define CLK_MEM_EXTRA    6'h02
`endif

//--- common/dmad_pkg.sv
// Types shared by the move and add decoder
package dmad_pkg;
  typedef enum logic [3:0] {
    OP_NONE,
    OP_SEG_LOAD,
    OP_SEG_STORE,
    OP_TABLE_LOOKUP,
    OP_EA_LOAD,
    OP_FAR_DS,
    OP_FAR_ES,
    OP_FLAGS_TO_AH,
    OP_AH_TO_FLAGS,
    OP_ADD_RM,
    OP_ADC_RM,
    OP_ADD_IMM,
    OP_ADC_IMM,
    OP_ILLEGAL
  } op_e;
  typedef enum logic [2:0] {
    SEG_DEFAULT,
    SEG_ES,
    SEG_CS,
    SEG_SS,
    SEG_DS
  } seg_e;
  typedef logic [5:0] clocks_t;
endpackage

//--- hdl/dmad_cycle_table.sv
// Minimum clock count lookup per decoded operation
`timescale 1ns/10ps
`default_nettype none
`include "dmad_regs.svh"
module dmad_cycle_table (
  input  wire  dmad_pkg::op_e    i_op,
  input  wire  logic             i_mem,
  input  wire  logic             i_word,
  output var   dmad_pkg::clocks_t o_clocks
);
  import dmad_pkg::*;
  always_comb begin
    case (i_op)
      OP_SEG_LOAD:     o_clocks = i_mem ? `CLK_SEG_LOAD_M : `CLK_SEG_LOAD_R;
      OP_SEG_STORE:    o_clocks = i_mem ? `CLK_SEG_STORE_M : `CLK_SEG_STORE_R;
      OP_TABLE_LOOKUP: o_clocks = `CLK_TABLE_LOOKUP;
      OP_EA_LOAD:      o_clocks = `CLK_EA_LOAD;
      OP_FAR_DS:       o_clocks = `CLK_FAR_LOAD;
      OP_FAR_ES:       o_clocks = `CLK_FAR_LOAD;
      OP_FLAGS_TO_AH:  o_clocks = `CLK_FLAGS_TO_AH;
      OP_AH_TO_FLAGS:  o_clocks = `CLK_AH_TO_FLAGS;
      OP_ADD_RM,
      OP_ADC_RM:       o_clocks = i_mem ? `CLK_ADD_M : `CLK_ADD_R;
      OP_ADD_IMM,
      OP_ADC_IMM:      o_clocks = i_word ? `CLK_ADD_IMM16 : `CLK_ADD_IMM8;
      default:         o_clocks = 6'h00;
    endcase
  end
endmodule
`default_nettype wire

//--- hdl/dmad_opcode_class.sv
// First-byte classification: operation, addressing byte and prefix detection
`timescale 1ns/10ps
`default_nettype none
`include "dmad_regs.svh"
module dmad_opcode_class (
  input  wire  logic [7:0]    i_byte,
  output var   dmad_pkg::op_e o_op,
  output logic                o_needs_modrm,
  output logic                o_needs_imm,
  output logic                o_is_prefix,
  output var   dmad_pkg::seg_e o_prefix_seg
);
  import dmad_pkg::*;
  wire [7:0] rm_bits  = i_byte & `OPC_ADD_RM_MASK;
  wire [7:0] imm_bits = i_byte & `OPC_IMM_MASK;
  always_comb begin
    o_needs_modrm = 1'b1;
    o_needs_imm   = 1'b0;
    o_is_prefix   = 1'b0;
    o_prefix_seg  = SEG_DEFAULT;
    o_op          = OP_NONE;
    case (i_byte)
      `OPC_SEG_LOAD:     o_op = OP_SEG_LOAD;
      `OPC_SEG_STORE:    o_op = OP_SEG_STORE;
      `OPC_EA_LOAD:      o_op = OP_EA_LOAD;
      `OPC_FAR_DS:       o_op = OP_FAR_DS;
      `OPC_FAR_ES:       o_op = OP_FAR_ES;
      `OPC_TABLE_LOOKUP: o_op = OP_TABLE_LOOKUP;
      `OPC_FLAGS_TO_AH:  o_op = OP_FLAGS_TO_AH;
      `OPC_AH_TO_FLAGS:  o_op = OP_AH_TO_FLAGS;
      `OPC_PFX_ES:       o_prefix_seg = SEG_ES;
      `OPC_PFX_CS:       o_prefix_seg = SEG_CS;
      `OPC_PFX_SS:       o_prefix_seg = SEG_SS;
      `OPC_PFX_DS:       o_prefix_seg = SEG_DS;
      default: begin
        if (rm_bits == `OPC_ADD_RM) begin
          o_op = OP_ADD_RM;
        end else if (rm_bits == `OPC_ADC_RM) begin
          o_op = OP_ADC_RM;
        end else if (imm_bits == `OPC_ADD_IMM) begin
          o_op = OP_ADD_IMM;
        end else if (imm_bits == `OPC_ADC_IMM) begin
          o_op = OP_ADC_IMM;
        end
      end
    endcase
    if (o_prefix_seg != SEG_DEFAULT) begin
      o_is_prefix = 1'b1;
    end
    case (o_op)
      OP_TABLE_LOOKUP,
      OP_FLAGS_TO_AH,
      OP_AH_TO_FLAGS,
      OP_NONE:   o_needs_modrm = 1'b0;
      OP_ADD_IMM,
      OP_ADC_IMM: begin
        o_needs_modrm = 1'b0;
        o_needs_imm   = 1'b1;
      end
      default:   o_needs_modrm = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

//--- hdl/dmad_decoder.sv
// Data move and first addition decoder with minimum-clock sequencing
`timescale 1ns/10ps
`default_nettype none
`include "dmad_regs.svh"
module dmad_decoder (
  input  wire  logic              i_clk_sys,
  input  wire  logic              i_nrst,
  input  wire  logic              i_byte_valid,
  input  wire  logic [7:0]        i_byte,
  input  wire  logic              i_bus_wait,
  output logic                    o_byte_ready,
  output logic                    o_exec_start,
  output var   dmad_pkg::op_e     o_op,
  output var   dmad_pkg::seg_e    o_seg,
  output logic [7:0]              o_opcode,
  output logic [7:0]              o_modrm,
  output logic                    o_mem_operand,
  output logic                    o_word,
  output logic                    o_dir,
  output var   dmad_pkg::clocks_t o_min_clocks,
  output logic                    o_busy,
  output logic                    o_illegal
);
  import dmad_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_PREFIX,
    ST_MODRM,
    ST_IMM_LO,
    ST_IMM_HI,
    ST_EXEC
  } state_e;

  state_e     state_q, state_d;
  op_e        op_q;
  seg_e       seg_q;
  logic [7:0] opc_q;
  logic [7:0] modrm_q;
  logic       mem_q;
  logic       ill_q;
  clocks_t    cnt_q;
  logic [1:0] extra_q;
  logic       start_q;

  op_e     cls_op;
  logic    cls_modrm;
  logic    cls_imm;
  logic    cls_pfx;
  seg_e    cls_seg;
  clocks_t tbl_clocks;

  dmad_opcode_class u_class (
    .i_byte        (i_byte),
    .o_op          (cls_op),
    .o_needs_modrm (cls_modrm),
    .o_needs_imm   (cls_imm),
    .o_is_prefix   (cls_pfx),
    .o_prefix_seg  (cls_seg)
  );

  dmad_cycle_table u_table (
    .i_op     (op_q),
    .i_mem    (mem_q),
    .i_word   (opc_q[`OPC_W_BIT]),
    .o_clocks (tbl_clocks)
  );

  wire       take      = i_byte_valid && o_byte_ready;
  wire [1:0] mod_field = i_byte[`MODRM_MOD_HI:`MODRM_MOD_LO];
  wire       is_mem    = (mod_field != `MOD_REGISTER);
  // Far pointer loads have no register form, so mode 11 is flagged
  wire       far_op    = (op_q == OP_FAR_DS) || (op_q == OP_FAR_ES);
  wire       bad_form  = far_op && !is_mem;
  // Effective address load computes an address only; never a bus access
  wire       mem_use   = is_mem && (op_q != OP_EA_LOAD);
  wire       last_clk  = (cnt_q == 6'h01) && (extra_q == 2'h0);
  wire       opc_unk   = (cls_op == OP_NONE) && !cls_pfx;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OPCODE,
      ST_PREFIX: begin
        if (take) begin
          if (cls_pfx) begin
            state_d = ST_PREFIX;
          end else if (cls_modrm) begin
            state_d = ST_MODRM;
          end else if (cls_imm) begin
            state_d = ST_IMM_LO;
          end else begin
            state_d = ST_EXEC;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          state_d = ST_EXEC;
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          state_d = opc_q[`OPC_W_BIT] ? ST_IMM_HI : ST_EXEC;
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (last_clk) begin
          state_d = ST_OPCODE;
        end
      end
      default: state_d = ST_OPCODE;
    endcase
  end

  // Decoding stops while an instruction executes, so no queue byte is lost
  assign o_byte_ready = (state_q != ST_EXEC);

  wire to_exec = (state_d == ST_EXEC) && (state_q != ST_EXEC);

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_q <= ST_OPCODE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      op_q  <= OP_NONE;
      opc_q <= 8'h00;
      ill_q <= 1'b0;
    end else if (take && (state_q == ST_OPCODE || state_q == ST_PREFIX)
                 && !cls_pfx) begin
      op_q  <= opc_unk ? OP_ILLEGAL : cls_op;
      opc_q <= i_byte;
      ill_q <= opc_unk;
    end else if (take && state_q == ST_MODRM && bad_form) begin
      ill_q <= 1'b1;
    end
  end

  // Prefix holds only until the instruction it qualifies finishes
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      seg_q <= SEG_DEFAULT;
    end else if (take && cls_pfx && state_q != ST_MODRM
                 && state_q != ST_IMM_LO && state_q != ST_IMM_HI) begin
      seg_q <= cls_seg;
    end else if (state_q == ST_EXEC && last_clk) begin
      seg_q <= SEG_DEFAULT;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      modrm_q <= 8'h00;
      mem_q   <= 1'b0;
    end else if (take && (state_q == ST_OPCODE || state_q == ST_PREFIX)) begin
      modrm_q <= 8'h00;
      mem_q   <= 1'b0;
    end else if (take && state_q == ST_MODRM) begin
      modrm_q <= i_byte;
      mem_q   <= mem_use;
    end
  end

  // Prefix bytes add no clocks here; the count loads from the table on the first execute clock
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cnt_q <= 6'h00;
    end else if (state_q == ST_EXEC && cnt_q > 6'h01) begin
      cnt_q <= cnt_q - 6'h01;
    end else if (to_exec) begin
      cnt_q <= 6'h00;
    end else if (state_q == ST_EXEC && cnt_q == 6'h00) begin
      cnt_q <= (tbl_clocks == 6'h00) ? 6'h01 : tbl_clocks;
    end
  end

  // Memory forms may stretch by up to two clocks while the bus waits
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      extra_q <= 2'h0;
    end else if (to_exec) begin
      extra_q <= 2'h0;
    end else if (state_q == ST_EXEC && cnt_q == 6'h01 && extra_q != 2'h0) begin
      extra_q <= extra_q - 2'h1;
    end else if (state_q == ST_EXEC && cnt_q == 6'h00 && mem_q && i_bus_wait) begin
      extra_q <= 2'(`CLK_MEM_EXTRA);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= to_exec;
    end
  end

  assign o_exec_start  = start_q;
  assign o_op          = op_q;
  assign o_seg         = seg_q;
  assign o_opcode      = opc_q;
  assign o_modrm       = modrm_q;
  assign o_mem_operand = mem_q;
  assign o_word        = opc_q[`OPC_W_BIT];
  assign o_dir         = opc_q[1];
  assign o_min_clocks  = tbl_clocks;
  assign o_busy        = (state_q == ST_EXEC);
  assign o_illegal     = ill_q;

  // Count of clocks spent in execute, used only by the checks below
  logic [5:0] run_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst || state_q != ST_EXEC) begin
      run_q <= 6'h00;
    end else begin
      run_q <= run_q + 6'h01;
    end
  end
  wire leaving = (state_q == ST_EXEC) && (state_d == ST_OPCODE);

  seg_load_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_SEG_LOAD && !mem_q) |-> (run_q == 6'h02))
    else $error("segment load register form count wrong");
  seg_store_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_SEG_STORE && mem_q && extra_q == 2'h0
     && !$past(i_bus_wait)) |-> (run_q >= 6'h0B && run_q <= 6'h0D))
    else $error("segment store memory form count wrong");
  lookup_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_TABLE_LOOKUP) |-> (run_q == 6'h0B))
    else $error("table lookup count wrong");
  ea_no_mem_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (o_busy && op_q == OP_EA_LOAD) |-> !mem_q)
    else $error("effective address load marked as memory");
  far_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (take && state_q == ST_MODRM && far_op && mod_field == 2'h3)
    |=> o_illegal)
    else $error("far pointer register form not flagged");
  flags_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_FLAGS_TO_AH) |-> (run_q == 6'h02))
    else $error("flag copy count wrong");
  ah_flags_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_AH_TO_FLAGS) |-> (run_q == 6'h03))
    else $error("flag write count wrong");
  prefix_seg_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (take && state_q == ST_OPCODE && i_byte == 8'h26) |=> (o_seg == SEG_ES))
    else $error("extra segment prefix not held");
  add_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_ADD_RM && !mem_q) |-> (run_q == 6'h03))
    else $error("register add count wrong");
  adc_imm_clocks_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_ADC_IMM) |-> (run_q == (o_word ? 6'h04 : 6'h03)))
    else $error("carry immediate add count wrong");
  mem_extra_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && mem_q) |-> (run_q <= tbl_clocks + 6'h02))
    else $error("memory stretch beyond two clocks");

  // Remaining forms; memory forms may carry the two-clock stretch
  seg_store_reg_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_SEG_STORE && !mem_q) |-> (run_q == 6'h02))
    else $error("segment store register form count wrong");
  ea_clocks_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_EA_LOAD) |-> (run_q == 6'h06))
    else $error("effective address load count wrong");
  far_es_clocks_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_FAR_ES) |-> (run_q == 6'h12 || run_q == 6'h14))
    else $error("far pointer extra segment count wrong");
  add_mem_clocks_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_ADD_RM && mem_q)
    |-> (run_q == 6'h0A || run_q == 6'h0C))
    else $error("memory add count wrong");
  adc_rm_clocks_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && op_q == OP_ADC_RM && !mem_q) |-> (run_q == 6'h03))
    else $error("register carry add count wrong");
  seg_clear_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    leaving |=> (o_seg == SEG_DEFAULT))
    else $error("segment override outlived its instruction");
  reg_no_stretch_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (leaving && !mem_q && !o_illegal) |-> (run_q == tbl_clocks))
    else $error("register form count differs from table");
  start_pulse_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    o_exec_start |-> (o_busy && run_q == 6'h00) ##1 !o_exec_start)
    else $error("execute start pulse misplaced");

  far_load_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    leaving && op_q == OP_FAR_ES);
  prefixed_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    leaving && seg_q != SEG_DEFAULT && mem_q);
  stretched_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_busy && extra_q != 2'h0);
  illegal_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    leaving && o_illegal);
  word_imm_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    leaving && op_q == OP_ADC_IMM && o_word);
endmodule
`default_nettype wire

//--- verification/dmad_queue_model.sv
// Prefetch queue model that offers instruction bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module dmad_queue_model (
  input  wire logic       i_clk,
  input  wire logic       i_ready,
  input  wire logic       i_slow,
  output logic            o_valid,
  output logic [7:0]      o_byte
);
  logic [7:0] fifo [$];
  logic       rdy;
  logic       took;
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h5A;
    rdy     = 1'b0;
    forever begin
      @(negedge i_clk);
      took = o_valid && rdy;
      if (took) begin
        void'(fifo.pop_front());
      end
      // Bytes sit ready in the queue; slow mode leaves a gap after each
      if (fifo.size() > 0 && !(i_slow && took)) begin
        o_valid = 1'b1;
        o_byte  = fifo[0];
      end else begin
        // Idle bus flips every cycle so a stale byte never looks valid
        o_valid = 1'b0;
        o_byte  = ~o_byte;
      end
      #1 rdy = i_ready;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_data_move_and_add_decoder.sv
// Self-checking bench for the move and add decoder
`timescale 1ns/10ps
`default_nettype none
module tb_data_move_and_add_decoder;
  import dmad_pkg::*;
  logic       i_clk_sys, i_nrst, i_byte_valid, i_bus_wait, slow;
  logic [7:0] i_byte, o_opcode, o_modrm;
  logic       o_byte_ready, o_exec_start, o_mem_operand, o_word, o_dir;
  logic       o_busy, o_illegal;
  op_e        o_op;
  seg_e       o_seg;
  clocks_t    o_min_clocks;
  int         err_count, total_checks;

  dmad_decoder dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .i_bus_wait(i_bus_wait), .o_byte_ready(o_byte_ready),
    .o_exec_start(o_exec_start), .o_op(o_op), .o_seg(o_seg),
    .o_opcode(o_opcode), .o_modrm(o_modrm), .o_mem_operand(o_mem_operand),
    .o_word(o_word), .o_dir(o_dir), .o_min_clocks(o_min_clocks),
    .o_busy(o_busy), .o_illegal(o_illegal)
  );
  dmad_queue_model q (
    .i_clk(i_clk_sys), .i_ready(o_byte_ready), .i_slow(slow),
    .o_valid(i_byte_valid), .o_byte(i_byte)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b [$]);
    foreach (b[i]) q.push(b[i]);
  endtask

  // Waits for one execute phase and judges decode and occupancy
  task automatic expect_exec(input op_e op, input logic [7:0] opc,
                             input logic [5:0] clk, input logic mem,
                             input seg_e seg, input logic ill,
                             input int extra);
    int k;
    int n;
    k = 0;
    while (o_busy !== 1'b1 && k < 20) begin
      @(negedge i_clk_sys);
      k++;
    end
    check("busy_seen", 32'(k < 20), 32'h1);
    n = 0;
    while (o_busy === 1'b1 && n < 40) begin
      if (n == 0) begin
        check("illegal", 32'(o_illegal), 32'(ill));
        check("opcode", 32'(o_opcode), 32'(opc));
        check("word", 32'(o_word), 32'(opc[0]));
        check("dir", 32'(o_dir), 32'(opc[1]));
        check("seg", 32'(o_seg), 32'(seg));
        if (mem !== 1'bx) check("mem", 32'(o_mem_operand), 32'(mem));
        if (!ill) check("op", 32'(o_op), 32'(op));
        if (!ill) check("min_clk", 32'(o_min_clocks), 32'(clk));
        check("start", 32'(o_exec_start), 32'h1);
      end
      if (n == 1) check("start_end", 32'(o_exec_start), 32'h0);
      @(negedge i_clk_sys);
      n++;
    end
    // Illegal forms have no documented occupancy, so length is left open
    if (!ill) check("busy_len", 32'(n), 32'(1 + clk + extra));
    check("seg_clear", 32'(o_seg), 32'(SEG_DEFAULT));
  endtask

  task automatic t_seg_moves;
    send('{8'h8E, 8'hC0, 8'h8E, 8'h00, 8'h8C, 8'hC0, 8'h8C, 8'h00});
    expect_exec(OP_SEG_LOAD, 8'h8E, 6'h02, 1'b0, SEG_DEFAULT, 1'b0, 0);
    check("modrm", 32'(o_modrm), 32'hC0);
    expect_exec(OP_SEG_LOAD, 8'h8E, 6'h09, 1'b1, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_SEG_STORE, 8'h8C, 6'h02, 1'b0, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_SEG_STORE, 8'h8C, 6'h0B, 1'b1, SEG_DEFAULT, 1'b0, 0);
  endtask

  task automatic t_single;
    send('{8'hD7, 8'h9F, 8'h9E, 8'h8D, 8'h00});
    expect_exec(OP_TABLE_LOOKUP, 8'hD7, 6'h0B, 1'bx, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_FLAGS_TO_AH, 8'h9F, 6'h02, 1'bx, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_AH_TO_FLAGS, 8'h9E, 6'h03, 1'bx, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_EA_LOAD, 8'h8D, 6'h06, 1'b0, SEG_DEFAULT, 1'b0, 0);
  endtask

  task automatic t_far;
    send('{8'hC5, 8'h00, 8'hC5, 8'hC0, 8'hC4, 8'h00, 8'hC4, 8'hC0});
    expect_exec(OP_FAR_DS, 8'hC5, 6'h12, 1'b1, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_FAR_DS, 8'hC5, 6'h12, 1'bx, SEG_DEFAULT, 1'b1, 0);
    expect_exec(OP_FAR_ES, 8'hC4, 6'h12, 1'b1, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_FAR_ES, 8'hC4, 6'h12, 1'bx, SEG_DEFAULT, 1'b1, 0);
    // Unknown byte executes one clock flagged illegal
    send('{8'hF4});
    expect_exec(OP_ILLEGAL, 8'hF4, 6'h00, 1'bx, SEG_DEFAULT, 1'b1, 0);
    check("unknown_op", 32'(o_op), 32'(OP_ILLEGAL));
  endtask

  task automatic t_prefix;
    logic [7:0] pfx [4] = '{8'h26, 8'h2E, 8'h36, 8'h3E};
    seg_e       sg  [4] = '{SEG_ES, SEG_CS, SEG_SS, SEG_DS};
    for (int i = 0; i < 4; i++) begin
      send('{pfx[i], 8'h8E, 8'h00});
      expect_exec(OP_SEG_LOAD, 8'h8E, 6'h09, 1'b1, sg[i], 1'b0, 0);
    end
  endtask

  task automatic t_add;
    for (int i = 0; i < 4; i++) begin
      send('{8'(i), 8'hC0, 8'(i), 8'h00, 8'(8'h10 | i), 8'hC0});
      expect_exec(OP_ADD_RM, 8'(i), 6'h03, 1'b0, SEG_DEFAULT, 1'b0, 0);
      expect_exec(OP_ADD_RM, 8'(i), 6'h0A, 1'b1, SEG_DEFAULT, 1'b0, 0);
      expect_exec(OP_ADC_RM, 8'(8'h10 | i), 6'h03, 1'b0, SEG_DEFAULT, 1'b0, 0);
    end
    send('{8'h12, 8'h00});
    expect_exec(OP_ADC_RM, 8'h12, 6'h0A, 1'b1, SEG_DEFAULT, 1'b0, 0);
    slow = 1'b1;
    send('{8'h04, 8'h12, 8'h05, 8'h34, 8'h12, 8'h14, 8'h56, 8'h15, 8'h78, 8'h9A});
    expect_exec(OP_ADD_IMM, 8'h04, 6'h03, 1'bx, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_ADD_IMM, 8'h05, 6'h04, 1'bx, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_ADC_IMM, 8'h14, 6'h03, 1'bx, SEG_DEFAULT, 1'b0, 0);
    expect_exec(OP_ADC_IMM, 8'h15, 6'h04, 1'bx, SEG_DEFAULT, 1'b0, 0);
    slow = 1'b0;
  endtask

  // Wait only stretches memory forms; a register form keeps its minimum
  task automatic t_wait;
    i_bus_wait = 1'b1;
    send('{8'h8E, 8'h00, 8'h8E, 8'hC0});
    expect_exec(OP_SEG_LOAD, 8'h8E, 6'h09, 1'b1, SEG_DEFAULT, 1'b0, 2);
    expect_exec(OP_SEG_LOAD, 8'h8E, 6'h02, 1'b0, SEG_DEFAULT, 1'b0, 0);
    i_bus_wait = 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge i_clk_sys);
    err_count++;
    finish_test();
  end

  initial begin
    err_count    = 0;
    total_checks = 0;
    i_nrst       = 1'b0;
    i_bus_wait   = 1'b0;
    slow         = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    check("rst_ready", 32'(o_byte_ready), 32'h1);
    check("rst_busy", 32'(o_busy), 32'h0);
    check("rst_op", 32'(o_op), 32'(OP_NONE));
    t_seg_moves();
    t_single();
    t_far();
    t_prefix();
    t_add();
    t_wait();
    finish_test();
  end
endmodule
`default_nettype wire
